/* File: tcp_consts.svh */
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH
// ==========================================
// register indices (byte address = 4 * index)
`define TCP_A_CTRL     4'h0
`define TCP_A_PERIOD   4'h1
`define TCP_A_CMP0     4'h2
`define TCP_A_CMP1     4'h3
`define TCP_A_DEAD     4'h4
`define TCP_A_DIV      4'h5
`define TCP_A_COUNT    4'h6
`define TCP_A_CAPT     4'h7
`define TCP_A_STAT     4'h8
`define TCP_A_TRSEL    4'h9
// ==========================================
// control fields
`define TCP_C_EN       0
`define TCP_C_RELOAD   1
`define TCP_C_KILLLVL  2
`define TCP_C_INV      3
`define TCP_C_SWSTART  4
`define TCP_C_SWCAPT   5
// ==========================================
// trigger select fields (3 bits each, value 5..7 = none)
`define TCP_T_START_LO 0
`define TCP_T_CAPT_LO  4
`define TCP_T_KILL_LO  8
`define TCP_T_NONE     3'h7
// ==========================================
// widths and reset values
`define TCP_W          16
`define TCP_NTRIG      5
`define TCP_PERIOD_RST 16'hffff
`define TCP_ZERO16     16'h0000
`define TCP_ONE16      16'h0001
`define TCP_CTRL_RST   16'h0002
`define TCP_TRSEL_RST  16'h0777
`endif

/* File: tcp_pkg.sv */
package tcp_pkg;
  typedef enum logic [1:0] {
    TCP_IDLE = 2'b00,
    TCP_RUN  = 2'b01,
    TCP_HALT = 2'b11
  } tcp_state_t;

  typedef struct packed {
    tcp_state_t  st;
    logic [15:0] ctrl;
    logic [15:0] period;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] dead;
    logic [15:0] div;
    logic [15:0] div_cnt;
    logic [15:0] count;
    logic [15:0] capt;
    logic [15:0] trsel;
    logic [4:0]  trig_m;
    logic [4:0]  trig_s;
    logic [4:0]  trig_d;
    logic        pwm;
    logic [15:0] dt_cnt;
    logic        out_p;
    logic        out_n;
    logic        ovf;
    logic        und;
    logic        match;
    logic [2:0]  sticky;
    logic [15:0] rdata;
  } tcp_state_s_t;
endpackage : tcp_pkg

/* File: tcp_timer_counter_pwm_unit.sv */
// ==========================================
`timescale 1ns/10ps
`include "tcp_consts.svh"
module tcp_timer_counter_pwm_unit import tcp_pkg::*; (
  input  wire logic        clk_sys,                   // 20 MHz clock
  input  wire logic        rst,                       // async, active high
  input  wire logic [3:0]  addr,                      // register index
  input  wire logic [15:0] wdata,                     // write data
  input  wire logic        wr,                        // write strobe
  input  wire logic        rd,                        // read strobe
  output logic      [15:0] rdata,                     // read data, next cycle
  input  wire logic [4:0]  trigger_input,             // pins, [0]..[4]
  output logic             primary_pwm_output,        // true pwm
  output logic             complementary_pwm_output,  // complement pwm
  output logic             overflow_output,           // one-cycle pulse
  output logic             underflow_output,          // one-cycle pulse
  output logic             match_output,              // one-cycle pulse
  output logic [15:0]      count_value                // live count
);

  tcp_state_s_t s_reg;
  tcp_state_s_t s_next;

  logic        tick;
  logic        start_ev;
  logic        capt_ev;
  logic        kill_lvl;
  logic        at_period;
  logic        en_now;
  logic [4:0]  rise;
  logic [2:0]  sel_start;
  logic [2:0]  sel_capt;
  logic [2:0]  sel_kill;

  function automatic logic pick(input logic [4:0] v, input logic [2:0] s);
    pick = (s < 3'(`TCP_NTRIG)) ? v[s] : 1'b0;
  endfunction : pick

  // ==========================================
  // next state
  always_comb begin
    s_next = s_reg;
    // two-flop synchroniser; only trig_s and later are read by logic
    s_next.trig_m = trigger_input;
    s_next.trig_s = s_reg.trig_m;
    s_next.trig_d = s_reg.trig_s;
    rise      = s_reg.trig_s & ~s_reg.trig_d;
    sel_start = s_reg.trsel[`TCP_T_START_LO +: 3];
    sel_capt  = s_reg.trsel[`TCP_T_CAPT_LO +: 3];
    sel_kill  = s_reg.trsel[`TCP_T_KILL_LO +: 3];
    start_ev  = pick(rise, sel_start) | (wr && addr == `TCP_A_CTRL
                && wdata[`TCP_C_SWSTART]);
    capt_ev   = pick(rise, sel_capt) | (wr && addr == `TCP_A_CTRL
                && wdata[`TCP_C_SWCAPT]);
    kill_lvl  = pick(s_reg.trig_s, sel_kill);

    // clock divider: tick every div+1 system cycles
    // >= so a smaller divider written mid-count cannot stall a full wrap
    tick = (s_reg.div_cnt >= s_reg.div);
    s_next.div_cnt = tick ? `TCP_ZERO16 : s_reg.div_cnt + `TCP_ONE16;

    at_period = (s_reg.count == s_reg.period);
    // enable written with the sw start bit counts for that start from idle; halt uses the stored enable
    en_now    = (wr && addr == `TCP_A_CTRL) ? wdata[`TCP_C_EN]
                : s_reg.ctrl[`TCP_C_EN];
    s_next.ovf   = 1'b0;
    s_next.und   = 1'b0;
    s_next.match = 1'b0;

    if (capt_ev) begin
      s_next.capt = s_reg.count;
    end

    unique case (s_reg.st)
      TCP_IDLE: begin
        if (start_ev && en_now) begin
          s_next.st    = TCP_RUN;
          s_next.count = `TCP_ZERO16;
        end
      end
      TCP_RUN: begin
        if (!s_reg.ctrl[`TCP_C_EN]) begin
          s_next.st = TCP_IDLE;
        end else if (tick) begin
          if (at_period) begin
            s_next.ovf = 1'b1;
            if (s_reg.ctrl[`TCP_C_RELOAD]) begin
              s_next.count = `TCP_ZERO16;
              s_next.und   = 1'b1;
            end else begin
              s_next.st = TCP_HALT;
            end
          end else begin
            s_next.count = s_reg.count + `TCP_ONE16;
          end
          if (s_reg.count == s_reg.cmp0 || s_reg.count == s_reg.cmp1) begin
            s_next.match = 1'b1;
          end
        end
      end
      TCP_HALT: begin
        if (!s_reg.ctrl[`TCP_C_EN]) begin
          s_next.st = TCP_IDLE;
        end else if (start_ev) begin
          s_next.st    = TCP_RUN;
          s_next.count = `TCP_ZERO16;
        end
      end
      default: s_next.st = TCP_IDLE;
    endcase

    // pwm high from cmp0 up to cmp1 (edge modes via cmp0 = 0)
    if (s_reg.st != TCP_RUN) begin
      s_next.pwm = 1'b0;
    end else if (s_next.count == s_reg.cmp0) begin
      s_next.pwm = 1'b1;
    end else if (s_next.count == s_reg.cmp1) begin
      s_next.pwm = 1'b0;
    end

    // dead band: a falling edge waits dead ticks on the complement side with inv set or clear; a rising edge waits on the true side only with inv clear
    if (s_next.pwm != s_reg.pwm) begin
      s_next.dt_cnt = s_reg.dead;
    end else if (tick && s_reg.dt_cnt != `TCP_ZERO16) begin
      s_next.dt_cnt = s_reg.dt_cnt - `TCP_ONE16;
    end
    s_next.out_p = s_next.pwm && s_next.dt_cnt == `TCP_ZERO16
                   ? 1'b1 : (s_next.pwm ? s_reg.out_p & s_next.pwm
                   : 1'b0);
    s_next.out_n = !s_next.pwm && s_next.dt_cnt == `TCP_ZERO16
                   ? 1'b1 : 1'b0;
    if (s_reg.ctrl[`TCP_C_INV]) begin
      s_next.out_p = ~s_next.out_p;
      s_next.out_n = ~s_next.out_n;
    end
    // kill overrides everything; its flops follow the synchroniser only
    if (kill_lvl) begin
      s_next.out_p = s_reg.ctrl[`TCP_C_KILLLVL];
      s_next.out_n = s_reg.ctrl[`TCP_C_KILLLVL];
    end

    // sticky event bits: set wins over clear-on-read
    if (rd && addr == `TCP_A_STAT) begin
      s_next.sticky = 3'h0;
    end
    s_next.sticky = s_next.sticky | {s_next.match, s_next.und, s_next.ovf};

    // register writes
    if (wr) begin
      unique case (addr)
        `TCP_A_CTRL:   s_next.ctrl   = wdata;
        `TCP_A_PERIOD: s_next.period = wdata;
        `TCP_A_CMP0:   s_next.cmp0   = wdata;
        `TCP_A_CMP1:   s_next.cmp1   = wdata;
        `TCP_A_DEAD:   s_next.dead   = wdata;
        `TCP_A_DIV:    s_next.div    = wdata;
        `TCP_A_TRSEL:  s_next.trsel  = wdata;
        default: ;
      endcase
    end
    s_next.ctrl[`TCP_C_SWSTART] = 1'b0;
    s_next.ctrl[`TCP_C_SWCAPT]  = 1'b0;

    // register reads; unmapped reads as zero
    s_next.rdata = `TCP_ZERO16;
    if (rd) begin
      unique case (addr)
        `TCP_A_CTRL:   s_next.rdata = s_reg.ctrl;
        `TCP_A_PERIOD: s_next.rdata = s_reg.period;
        `TCP_A_CMP0:   s_next.rdata = s_reg.cmp0;
        `TCP_A_CMP1:   s_next.rdata = s_reg.cmp1;
        `TCP_A_DEAD:   s_next.rdata = s_reg.dead;
        `TCP_A_DIV:    s_next.rdata = s_reg.div;
        `TCP_A_COUNT:  s_next.rdata = s_reg.count;
        `TCP_A_CAPT:   s_next.rdata = s_reg.capt;
        `TCP_A_STAT:   s_next.rdata = {11'h000, s_reg.st, s_reg.sticky};
        `TCP_A_TRSEL:  s_next.rdata = s_reg.trsel;
        default:       s_next.rdata = `TCP_ZERO16;
      endcase
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg        <= '0;
      s_reg.ctrl   <= `TCP_CTRL_RST;
      s_reg.period <= `TCP_PERIOD_RST;
      s_reg.trsel  <= `TCP_TRSEL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata                    = s_reg.rdata;
  assign primary_pwm_output       = s_reg.out_p;
  assign complementary_pwm_output = s_reg.out_n;
  assign overflow_output          = s_reg.ovf;
  assign underflow_output         = s_reg.und;
  assign match_output             = s_reg.match;
  assign count_value              = s_reg.count;

  // ==========================================
  // checks
  sequence s_kill_seen;
    kill_lvl;
  endsequence

  a_count_bound: assert property (@(posedge clk_sys) disable iff (rst)
    s_reg.st == TCP_RUN && s_reg.count <= s_reg.period && $stable(s_reg.period)
    |=> s_reg.count <= s_reg.period || s_reg.st != TCP_RUN)
    else $error("count passed period");
  a_capture_val: assert property (@(posedge clk_sys) disable iff (rst)
    capt_ev |=> s_reg.capt == $past(s_reg.count))
    else $error("capture lost count");
  a_halt_reload: assert property (@(posedge clk_sys) disable iff (rst)
    s_reg.st == TCP_RUN && tick && at_period && s_reg.ctrl[`TCP_C_EN]
    && !capt_ev |=> (s_reg.count == `TCP_ZERO16) || s_reg.st == TCP_HALT)
    else $error("period end wrong");
  a_pwm_cmp0: assert property (@(posedge clk_sys) disable iff (rst)
    s_reg.st == TCP_RUN && s_next.st == TCP_RUN
    && s_next.count == s_reg.cmp0 |=> s_reg.pwm)
    else $error("pwm not set at compare");
  a_no_overlap: assert property (@(posedge clk_sys) disable iff (rst)
    !s_reg.ctrl[`TCP_C_INV] && !$past(kill_lvl) |-> !(s_reg.out_p && s_reg.out_n))
    else $error("outputs overlap");
  a_kill_force: assert property (@(posedge clk_sys) disable iff (rst)
    s_kill_seen |=> s_reg.out_p == $past(s_reg.ctrl[`TCP_C_KILLLVL])
    && s_reg.out_n == $past(s_reg.ctrl[`TCP_C_KILLLVL]))
    else $error("kill not applied");
  a_trig_sync: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |-> ##2 s_reg.trig_s == $past(trigger_input, 2))
    else $error("trigger sync broken");
  a_pulse_one: assert property (@(posedge clk_sys) disable iff (rst)
    s_reg.ovf |=> !s_reg.ovf || tick)
    else $error("overflow pulse too long");
  a_div_tick: assert property (@(posedge clk_sys) disable iff (rst)
    tick && $stable(s_reg.div) |=> s_reg.div_cnt == `TCP_ZERO16)
    else $error("divider not restarted");

endmodule : tcp_timer_counter_pwm_unit

/* File: tcp_gate_drv_model.sv */
`timescale 1ns/10ps
module tcp_gate_drv_model (
  input  wire logic       clk_sys, // system clock
  input  wire logic       rst,     // async reset
  input  wire logic       gate_hi, // true gate drive
  input  wire logic       gate_lo, // complementary gate drive
  output logic      [4:0] trig     // trigger pins 0..4
);
  int hi_cnt;
  int lo_cnt;
  int shoot_cnt;
  initial trig = 5'h00;
  // ==========================================
  // trigger sources
  task automatic drive(input int idx, input logic lvl, input int len);
    @(posedge clk_sys);
    trig[idx] <= lvl;
    repeat (len) @(posedge clk_sys);
  endtask : drive
  // ==========================================
  // half bridge: both gates on is a shoot-through
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hi_cnt    <= 0;
      lo_cnt    <= 0;
      shoot_cnt <= 0;
    end else begin
      hi_cnt    <= hi_cnt + int'(gate_hi);
      lo_cnt    <= lo_cnt + int'(gate_lo);
      shoot_cnt <= shoot_cnt + int'(gate_hi & gate_lo);
    end
  end
endmodule : tcp_gate_drv_model

/* File: timer_counter_pwm_test.sv */
`timescale 1ns/10ps
`include "tcp_consts.svh"
module timer_counter_pwm_test;
  typedef struct packed {
    logic [3:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } tcp_row_t;
  logic        clk_sys;
  logic        rst;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [4:0]  trig;
  logic        pwm_p;
  logic        pwm_n;
  logic [2:0]  ev;
  logic [15:0] count_value;
  logic [15:0] v;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          t0;
  int          t1;
  int          s0;
  tcp_row_t    rows [8] = '{
    '{`TCP_A_PERIOD, 16'h1234, 16'h1234}, '{`TCP_A_CMP0, 16'h00aa, 16'h00aa},
    '{`TCP_A_CMP1, 16'h0055, 16'h0055}, '{`TCP_A_DEAD, 16'h0003, 16'h0003},
    '{`TCP_A_DIV, 16'hffff, 16'hffff}, '{`TCP_A_TRSEL, 16'h0234, 16'h0234},
    '{`TCP_A_CAPT, 16'h1111, 16'h0000}, '{4'ha, 16'h5555, 16'h0000}};

  tcp_timer_counter_pwm_unit i_tcp_timer_counter_pwm_unit (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .trigger_input(trig),
    .primary_pwm_output(pwm_p), .complementary_pwm_output(pwm_n),
    .overflow_output(ev[0]), .underflow_output(ev[1]),
    .match_output(ev[2]), .count_value(count_value));
  tcp_gate_drv_model i_tcp_gate_drv_model (
    .clk_sys(clk_sys), .rst(rst), .gate_hi(pwm_p), .gate_lo(pwm_n),
    .trig(trig));

  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // returns -1 when no pulse shows within 60 cycles
  task automatic wait_ev(input int k, output int at);
    at = -1;
    for (int i = 0; i < 60 && at < 0; i++) begin
      @(posedge clk_sys);
      #1;
      if (ev[k] === 1'b1)
        at = cyc;
    end
    if (at >= 0) begin
      @(posedge clk_sys);
      #1;
      check("pulse width", {15'h0000, ev[k]}, 16'h0000);
    end
  endtask : wait_ev
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // ==========================================
  // clock, cycle count, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  initial begin
    #1000000;
    n_errors++;
    report_and_stop();
  end

  // ==========================================
  // tests
  initial begin
    rst   = 1'b1;
    addr  = 4'h0;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v);
      check("readback", v, rows[i].e);
    end
    // second reset after the register writes must restore defaults
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(`TCP_A_CTRL, v);
    check("ctrl rst", v, `TCP_CTRL_RST);
    rd_reg(`TCP_A_PERIOD, v);
    check("period rst", v, `TCP_PERIOD_RST);
    rd_reg(`TCP_A_TRSEL, v);
    check("trsel rst", v, `TCP_TRSEL_RST);
    // auto reload, period 4, tick every clock
    wr_reg(`TCP_A_PERIOD, 16'h0004);
    wr_reg(`TCP_A_CMP0, 16'h0001);
    wr_reg(`TCP_A_CMP1, 16'h0003);
    wr_reg(`TCP_A_DEAD, 16'h0001);
    wr_reg(`TCP_A_CTRL, 16'h0013);
    wait_ev(0, t0);
    wait_ev(0, t1);
    check("ovf gap", 16'(t1 - t0), 16'h0005);
    wait_ev(1, t0);
    wait_ev(1, t1);
    check("und gap", 16'(t1 - t0), 16'h0005);
    wait_ev(2, t0);
    check("match", 16'(t0 > 0), 16'h0001);
    t0 = i_tcp_gate_drv_model.hi_cnt;
    t1 = i_tcp_gate_drv_model.lo_cnt;
    s0 = i_tcp_gate_drv_model.shoot_cnt;
    repeat (50) @(posedge clk_sys);
    s0 = i_tcp_gate_drv_model.shoot_cnt - s0;
    check("overlap", 16'(s0), 16'h0000);
    check("true on", 16'(i_tcp_gate_drv_model.hi_cnt > t0), 16'h0001);
    check("compl on", 16'(i_tcp_gate_drv_model.lo_cnt > t1), 16'h0001);
    // kill from pin 4 while running
    wr_reg(`TCP_A_TRSEL, 16'h0477);
    i_tcp_gate_drv_model.drive(4, 1'b1, 4);
    s0 = 0;
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      s0 += int'(pwm_p | pwm_n);
    end
    check("killed", 16'(s0), 16'h0000);
    t0 = i_tcp_gate_drv_model.hi_cnt;
    i_tcp_gate_drv_model.drive(4, 1'b0, 30);
    check("unkill", 16'(i_tcp_gate_drv_model.hi_cnt > t0), 16'h0001);
    // halt mode, then capture from pin 2
    wr_reg(`TCP_A_CTRL, 16'h0000);
    wr_reg(`TCP_A_TRSEL, 16'h0727);
    wr_reg(`TCP_A_CTRL, 16'h0011);
    wait_ev(0, t0);
    wait_ev(0, t1);
    check("halt", 16'(t1), 16'hffff);
    check("halt count", count_value, 16'h0004);
    i_tcp_gate_drv_model.drive(2, 1'b1, 2);
    i_tcp_gate_drv_model.drive(2, 1'b0, 4);
    rd_reg(`TCP_A_CAPT, v);
    check("capture", v, 16'h0004);
    // start from pin 0 with divide by two
    wr_reg(`TCP_A_CTRL, 16'h0000);
    wr_reg(`TCP_A_TRSEL, 16'h0770);
    wr_reg(`TCP_A_DIV, 16'h0001);
    wr_reg(`TCP_A_CTRL, 16'h0003);
    wait_ev(0, t0);
    check("no start", 16'(t0), 16'hffff);
    i_tcp_gate_drv_model.drive(0, 1'b1, 2);
    i_tcp_gate_drv_model.drive(0, 1'b0, 0);
    wait_ev(0, t0);
    wait_ev(0, t1);
    check("div gap", 16'(t1 - t0), 16'h000a);
    rd_reg(`TCP_A_STAT, v);
    check("status", v, 16'h000f);
    report_and_stop();
  end
endmodule : timer_counter_pwm_test
